//--- sim/host_bus_model.sv
// behavioural host bus master driving the shared pins
`timescale 1ns/1ps
module host_bus_model (
    // logical host controls, active high
    input wire logic [3:0] i_ctl,
    input wire logic i_as,
    input wire logic [7:0] i_byte,
    // polarity per pin, 0 active low
    input wire logic [3:0] i_pol,
    input wire logic i_as_pol,
    // pin levels
    output logic [3:0] o_pin,
    output logic o_as_pin,
    output logic [7:0] o_byte
);
    assign o_pin = i_ctl ^ ~i_pol;
    assign o_as_pin = i_as ^ ~i_as_pol;
    assign o_byte = i_byte;
endmodule : host_bus_model

//--- sim/host_pin_monitor.sv
// concurrent checks on the host port pin function mux ports
`timescale 1ns/1ps
module host_pin_monitor #(
    parameter int unsigned NPINS = host_pin_pkg::PIN_COUNT
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // configuration
    input wire logic i_host_function_select,
    input wire logic i_muxed_bus,
    input wire logic i_double_strobe,
    input wire logic i_pol_data_strobe,
    // gpio and shared pins
    input wire logic [2*NPINS-1:0] i_gpio_mode,
    input wire logic [NPINS-1:0] i_gpio_out,
    input wire logic [NPINS-1:0] i_pin,
    input wire logic [NPINS-1:0] o_pin,
    input wire logic [NPINS-1:0] o_pin_oe,
    input wire logic [NPINS-1:0] o_gpio_in,
    // decoded host controls
    input wire logic o_host_addr_bit_two,
    input wire logic o_host_upper_addr_bit_nine,
    input wire logic o_host_upper_addr_bit_ten,
    input wire logic o_host_read_write_dir,
    input wire logic o_host_read_strobe,
    input wire logic o_host_write_strobe,
    input wire logic o_host_data_strobe,
    input wire logic o_host_chip_select,
    input wire logic o_host_addr_strobe,
    input wire logic [host_pin_pkg::DATA_W-1:0] o_host_data_in
);
    // ==================================================
    // helpers
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    logic hs;
    logic gp;
    assign hs = i_ce && i_host_function_select;
    assign gp = i_ce && !i_host_function_select;
    // ==================================================
    // properties
    property p_host_no_drive;
        hs |=> o_pin_oe == '0;
    endproperty
    a_host_no_drive: assert property (p_host_no_drive) else $error("pin driven in host mode");
    property p_gpio_out;
        gp && i_gpio_mode[1:0] == host_pin_pkg::GPIO_OUT |=> o_pin_oe[0] && o_pin[0] == $past(i_gpio_out[0]);
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("gpio output not driven");
    property p_gpio_off;
        gp && i_gpio_mode[1:0] == host_pin_pkg::GPIO_OFF |=> !o_pin_oe[0] && !o_gpio_in[0];
    endproperty
    a_gpio_off: assert property (p_gpio_off) else $error("disconnected pin active");
    property p_gpio_quiet;
        gp [*3] |=> !(o_host_addr_bit_two | o_host_upper_addr_bit_nine | o_host_upper_addr_bit_ten
            | o_host_read_write_dir | o_host_read_strobe | o_host_write_strobe | o_host_data_strobe
            | o_host_chip_select | o_host_addr_strobe);
    endproperty
    a_gpio_quiet: assert property (p_gpio_quiet) else $error("host control active in gpio");
    property p_nonmux;
        (hs && !i_muxed_bus) [*3] |=> !o_host_upper_addr_bit_nine && !o_host_upper_addr_bit_ten && !o_host_addr_strobe;
    endproperty
    a_nonmux: assert property (p_nonmux) else $error("muxed function in non-muxed bus");
    property p_mux;
        (hs && i_muxed_bus) [*3] |=> !o_host_addr_bit_two && !o_host_chip_select;
    endproperty
    a_mux: assert property (p_mux) else $error("non-muxed function in muxed bus");
    property p_single;
        (hs && !i_double_strobe) [*3] |=> !o_host_read_strobe && !o_host_write_strobe;
    endproperty
    a_single: assert property (p_single) else $error("double strobe in single mode");
    property p_double;
        (hs && i_double_strobe) [*3] |=> !o_host_read_write_dir && !o_host_data_strobe;
    endproperty
    a_double: assert property (p_double) else $error("single strobe in double mode");
    property p_ds_pol;
        (hs && !i_double_strobe && $stable(i_pin[2]) && $stable(i_pol_data_strobe)) [*8]
            |-> o_host_data_strobe == (i_pin[2] == i_pol_data_strobe);
    endproperty
    a_ds_pol: assert property (p_ds_pol) else $error("data strobe polarity wrong");
    property p_addr_two;
        (hs && !i_muxed_bus && $stable(i_pin[0])) [*8] |-> o_host_addr_bit_two == i_pin[0];
    endproperty
    a_addr_two: assert property (p_addr_two) else $error("address bit two wrong");
    property p_ce_freeze;
        !i_ce |=> $stable(o_host_data_in) && $stable(o_pin_oe) && $stable(o_gpio_in) && $stable(o_host_data_strobe);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");
    // ==================================================
    // covers
    c_gpio_out: cover property (gp && i_gpio_mode[1:0] == host_pin_pkg::GPIO_OUT);
    c_double: cover property (hs && i_double_strobe && o_host_write_strobe);
    c_muxed: cover property (hs && i_muxed_bus && o_host_addr_strobe);
endmodule : host_pin_monitor

//--- sim/host_port_pin_function_mux_bench.sv
// testbench for the host port pin function mux
`timescale 1ns/1ps
module host_port_pin_function_mux_bench;
    // ==================================================
    // signals
    logic i_clk, i_arst_n, i_ce, i_host_function_select, i_muxed_bus, i_double_strobe, pol, as_v;
    logic i_pol_read_strobe, i_pol_write_strobe, i_pol_data_strobe, i_pol_chip_select, i_pol_addr_strobe;
    logic [7:0] i_gpio_mode, i_host_muxed_addr_data, o_host_low_addr, o_host_data_in, byte_v, host_v;
    logic [3:0] i_gpio_out, o_gpio_in, i_pin, o_pin, o_pin_oe, ctl, polv;
    logic i_addr_strobe_pin, o_host_addr_bit_two, o_host_upper_addr_bit_nine, o_host_upper_addr_bit_ten;
    logic o_host_read_write_dir, o_host_read_strobe, o_host_write_strobe, o_host_data_strobe;
    logic o_host_chip_select, o_host_addr_strobe;
    int mismatches = 0;
    int compares = 0;
    // one polarity drives all strobe ports; plain pins are never inverted
    assign {i_pol_read_strobe, i_pol_write_strobe, i_pol_data_strobe, i_pol_chip_select} = {4{pol}};
    assign i_pol_addr_strobe = pol;
    assign polv = {i_muxed_bus | pol, pol, ~i_double_strobe | pol, 1'b1};
    assign host_v = {o_host_addr_bit_two, o_host_upper_addr_bit_nine, o_host_upper_addr_bit_ten,
        o_host_read_write_dir, o_host_read_strobe, o_host_write_strobe, o_host_data_strobe, o_host_chip_select};
    host_port_pin_function_mux i_host_port_pin_function_mux (.*);
    host_bus_model i_host_bus_model (.i_ctl(ctl), .i_as(as_v), .i_byte(byte_v), .i_pol(polv),
        .i_as_pol(i_pol_addr_strobe), .o_pin(i_pin), .o_as_pin(i_addr_strobe_pin), .o_byte(i_host_muxed_addr_data));
    // ==================================================
    // tasks
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    function automatic logic [7:0] host_exp(input logic m, input logic d, input logic [3:0] c);
        return {!m & c[0], m & c[0], m & c[3], !d & c[1], d & c[1], d & c[2], !d & c[2], !m & c[3]};
    endfunction : host_exp
    // ==================================================
    // clock, watchdog, tests
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
    initial begin
        i_arst_n = 1'b0;
        i_ce = 1'b1;
        i_host_function_select = 1'b0;
        {i_muxed_bus, i_double_strobe, pol, as_v} = 4'h0;
        i_gpio_mode = 8'h00;
        i_gpio_out = 4'h0;
        ctl = 4'h0;
        byte_v = 8'h00;
        step(12);
        i_arst_n = 1'b1;
        step(8);
        chk("reset pins", {o_pin_oe, o_gpio_in}, 8'h00);
        chk("reset host", host_v, 8'h00);
        // all-ones polarity makes each pin level equal its control bit
        pol = 1'b1;
        for (int g = 0; g < 4; g++) begin
            i_gpio_mode = 8'(host_pin_pkg::GPIO_OUT) << (2 * g);
            i_gpio_out = 4'h1 << g;
            ctl = 4'h0;
            step(2);
            chk("gpio out", {o_pin_oe, 3'h0, o_pin[g]}, {4'h1 << g, 4'h1});
            i_gpio_mode = 8'(host_pin_pkg::GPIO_IN) << (2 * g);
            ctl = 4'hf;
            step(8);
            chk("gpio in", {o_pin_oe, o_gpio_in}, {4'h0, 4'h1 << g});
            i_gpio_mode = 8'h03 << (2 * g);
            step(8);
            chk("gpio off", {o_pin_oe, o_gpio_in}, 8'h00);
        end
        i_gpio_mode = 8'h00;
        i_host_function_select = 1'b1;
        for (int k = 0; k < 32; k++) begin
            {i_muxed_bus, i_double_strobe, pol} = k[4:2];
            ctl = 4'(k[1:0]) * 4'h5;
            step(8);
            chk("host decode", host_v, host_exp(i_muxed_bus, i_double_strobe, ctl));
            chk("host oe", {4'h0, o_pin_oe}, 8'h00);
        end
        // muxed byte goes to low address under the strobe, else to data
        {i_muxed_bus, pol, as_v} = 3'h5;
        byte_v = 8'h3c;
        step(8);
        chk("low addr", o_host_low_addr, 8'h3c);
        chk("addr strobe", {7'h00, o_host_addr_strobe}, 8'h01);
        as_v = 1'b0;
        byte_v = 8'hc3;
        step(8);
        chk("muxed data", o_host_data_in, 8'hc3);
        chk("low addr hold", o_host_low_addr, 8'h3c);
        i_muxed_bus = 1'b0;
        byte_v = 8'h5a;
        step(8);
        chk("plain data", o_host_data_in, 8'h5a);
        // enable low freezes the byte path, then it catches up
        i_ce = 1'b0;
        byte_v = 8'ha5;
        step(8);
        chk("ce hold", o_host_data_in, 8'h5a);
        i_ce = 1'b1;
        step(8);
        chk("ce run", o_host_data_in, 8'ha5);
        complete_run();
    end
endmodule : host_port_pin_function_mux_bench
bind host_port_pin_function_mux host_pin_monitor #(.NPINS(NPINS)) i_host_pin_monitor (.*);

//--- src/gpio_bit.sv
// one general-purpose port bit: input, output or disconnected
`timescale 1ns/1ps
module gpio_bit (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // control
    input wire logic i_gpio_en,
    input wire logic [1:0] i_mode,
    input wire logic i_out_val,
    // pin side
    input wire logic i_pin_level,
    output logic o_pin_out,
    output logic o_pin_oe,
    // software view
    output logic o_in_val
);
    logic out_r;
    logic out_nxt;
    logic oe_r;
    logic oe_nxt;
    logic in_r;
    logic in_nxt;

    // ==================================================
    // next state
    always_comb begin
        out_nxt = 1'b0;
        oe_nxt = 1'b0;
        in_nxt = 1'b0;
        if (i_gpio_en) begin
            case (i_mode)
                host_pin_pkg::GPIO_OUT: begin
                    out_nxt = i_out_val;
                    oe_nxt = 1'b1;
                    in_nxt = i_out_val;
                end
                host_pin_pkg::GPIO_IN: begin
                    in_nxt = i_pin_level;
                end
                // disconnected: no drive, input reads zero
                default: begin
                    in_nxt = 1'b0;
                end
            endcase
        end
    end

    // ==================================================
    // registers
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_r <= 1'b0;
            oe_r <= 1'b0;
            in_r <= 1'b0;
        end else if (i_ce) begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            in_r <= in_nxt;
        end
    end

    assign o_pin_out = out_r;
    assign o_pin_oe = oe_r;
    assign o_in_val = in_r;
endmodule : gpio_bit

//--- src/host_pin_pkg.sv
// constants for the host port pin function mux
package host_pin_pkg;
    // ==================================================
    // pin group
    localparam int unsigned PIN_COUNT = 4;
    localparam int unsigned PIN_ADDR = 0;
    localparam int unsigned PIN_RW = 1;
    localparam int unsigned PIN_DS = 2;
    localparam int unsigned PIN_CS = 3;
    localparam int unsigned DATA_W = 8;
    // ==================================================
    // address bit positions carried by the shared pins
    localparam int unsigned ADDR_LO_BIT = 2;
    localparam int unsigned ADDR_UP_BIT_A = 9;
    localparam int unsigned ADDR_UP_BIT_B = 10;
    // ==================================================
    // per-pin gpio mode codes
    localparam logic [1:0] GPIO_OFF = 2'h0;
    localparam logic [1:0] GPIO_IN = 2'h1;
    localparam logic [1:0] GPIO_OUT = 2'h2;
    // ==================================================
    // reset values: polarity 0 means active low
    localparam logic POL_RST = 1'b0;
    localparam logic [1:0] MODE_RST = GPIO_OFF;
    localparam int unsigned SYNC_STAGES = 3;
endpackage : host_pin_pkg

//--- src/host_port_pin_function_mux.sv
// pin function mux for the four shared host port pins and the muxed address/data byte
// How it works
// - host function on a non-multiplexed bus makes shared pin 0 the host address bit 2.
// - host function on a multiplexed bus makes shared pin 0 the upper host address bit 9.
// - host function on a multiplexed bus makes the chip-select pin the upper host address bit 10.
// - in gpio configuration port bits 10 to 13 are each set to input, output or disconnected.
// - after reset all pins are gpio disconnected, driving nothing and feeding no function.
// - host function with a single data strobe makes shared pin 1 the read/write direction input.
// - host function with two data strobes makes shared pin 1 the read strobe, polarity active low by default.
// - host function with a single data strobe makes shared pin 2 the data strobe, active low by default.
// - host function with two data strobes makes shared pin 2 the write strobe, active low by default.
// - host function on a non-multiplexed bus makes shared pin 3 the chip select, active low by default.
// - on a multiplexed bus the eight data pins carry low address and data, address strobe active low by default.
`timescale 1ns/1ps
module host_port_pin_function_mux #(
    parameter int unsigned NPINS = host_pin_pkg::PIN_COUNT,
    parameter int unsigned DW = host_pin_pkg::DATA_W
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // configuration
    input wire logic i_host_function_select,
    input wire logic i_muxed_bus,
    input wire logic i_double_strobe,
    input wire logic i_pol_read_strobe,
    input wire logic i_pol_write_strobe,
    input wire logic i_pol_data_strobe,
    input wire logic i_pol_chip_select,
    input wire logic i_pol_addr_strobe,
    // gpio control, port bits 10 to 13 at indices 0 to 3
    input wire logic [2*NPINS-1:0] i_gpio_mode,
    input wire logic [NPINS-1:0] i_gpio_out,
    output logic [NPINS-1:0] o_gpio_in,
    // shared pins
    input wire logic [NPINS-1:0] i_pin,
    output logic [NPINS-1:0] o_pin,
    output logic [NPINS-1:0] o_pin_oe,
    // address strobe and muxed address/data pins
    input wire logic i_addr_strobe_pin,
    input wire logic [DW-1:0] i_host_muxed_addr_data,
    // decoded host-bus controls, active high
    output logic o_host_addr_bit_two,
    output logic o_host_upper_addr_bit_nine,
    output logic o_host_upper_addr_bit_ten,
    output logic o_host_read_write_dir,
    output logic o_host_read_strobe,
    output logic o_host_write_strobe,
    output logic o_host_data_strobe,
    output logic o_host_chip_select,
    output logic o_host_addr_strobe,
    output logic [DW-1:0] o_host_low_addr,
    output logic [DW-1:0] o_host_data_in
);
    // ==================================================
    // synchronised pin levels
    logic [NPINS-1:0] lvl;
    logic as_lvl;
    logic [NPINS-1:0] gpio_oe;
    logic [NPINS-1:0] gpio_o;
    logic host_en;

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            pin_sync u_sync (
                .i_clk(i_clk),
                .i_arst_n(i_arst_n),
                .i_ce(i_ce),
                .i_pin(i_pin[g]),
                .o_level(lvl[g])
            );
            gpio_bit u_gpio (
                .i_clk(i_clk),
                .i_arst_n(i_arst_n),
                .i_ce(i_ce),
                .i_gpio_en(!i_host_function_select),
                .i_mode(i_gpio_mode[2*g+1:2*g]),
                .i_out_val(i_gpio_out[g]),
                .i_pin_level(lvl[g]),
                .o_pin_out(gpio_o[g]),
                .o_pin_oe(gpio_oe[g]),
                .o_in_val(o_gpio_in[g])
            );
        end
    endgenerate

    pin_sync u_as_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_pin(i_addr_strobe_pin),
        .o_level(as_lvl)
    );

    // ==================================================
    // settle guard after reset
    localparam int unsigned SETTLE_N = host_pin_pkg::SYNC_STAGES + 1;
    localparam int unsigned SETTLE_W = $clog2(SETTLE_N + 1);

    logic [SETTLE_W-1:0] settle_r;
    logic [SETTLE_W-1:0] settle_nxt;
    logic settled;

    // no host function until the filters hold real pin levels; the gpio input path reads them at once
    // the filters reset to 0, which an active-low strobe would read as asserted
    always_comb begin
        settled = (settle_r == SETTLE_W'(SETTLE_N));
        settle_nxt = settle_r;
        // counter stops at its end value, only reset restarts it
        if (!settled) begin
            settle_nxt = settle_r + SETTLE_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            settle_r <= '0;
        end else if (i_ce) begin
            settle_r <= settle_nxt;
        end
    end

    // ==================================================
    // polarity removed in one place, before any decode
    // pol 0 means active low, so the pin level is inverted
    logic rd_act;
    logic wr_act;
    logic ds_act;
    logic cs_act;
    logic as_act;
    assign rd_act = lvl[host_pin_pkg::PIN_RW] ^ ~i_pol_read_strobe;
    assign wr_act = lvl[host_pin_pkg::PIN_DS] ^ ~i_pol_write_strobe;
    assign ds_act = lvl[host_pin_pkg::PIN_DS] ^ ~i_pol_data_strobe;
    assign cs_act = lvl[host_pin_pkg::PIN_CS] ^ ~i_pol_chip_select;
    assign as_act = as_lvl ^ ~i_pol_addr_strobe;

    // host pins are inputs only, so the pins drive only in gpio output mode
    assign host_en = i_host_function_select && settled;
    assign o_pin = gpio_o;
    assign o_pin_oe = gpio_oe;

    // ==================================================
    // decoded controls
    logic a2_r;
    logic a2_nxt;
    logic a9_r;
    logic a9_nxt;
    logic a10_r;
    logic a10_nxt;
    logic rw_r;
    logic rw_nxt;
    logic rd_r;
    logic rd_nxt;
    logic wr_r;
    logic wr_nxt;
    logic ds_r;
    logic ds_nxt;
    logic cs_r;
    logic cs_nxt;
    logic as_r;
    logic as_nxt;
    logic [DW-1:0] la_r;
    logic [DW-1:0] la_nxt;
    logic [DW-1:0] din_r;
    logic [DW-1:0] din_nxt;

    // ==================================================
    // muxed byte: three stages plus agreement, like the control pins
    logic [DW-1:0] ad_s1_r;
    logic [DW-1:0] ad_s1_nxt;
    logic [DW-1:0] ad_s2_r;
    logic [DW-1:0] ad_s2_nxt;
    logic [DW-1:0] ad_s3_r;
    logic [DW-1:0] ad_s3_nxt;
    logic [DW-1:0] ad_lvl_r;
    logic [DW-1:0] ad_lvl_nxt;

    always_comb begin
        ad_s1_nxt = i_host_muxed_addr_data;
        ad_s2_nxt = ad_s1_r;
        ad_s3_nxt = ad_s2_r;
        ad_lvl_nxt = ad_lvl_r;
        // a byte caught mid-change is dropped, the last agreed byte stands
        if (ad_s2_r == ad_s3_r) begin
            ad_lvl_nxt = ad_s3_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ad_s1_r <= '0;
            ad_s2_r <= '0;
            ad_s3_r <= '0;
            ad_lvl_r <= '0;
        end else if (i_ce) begin
            ad_s1_r <= ad_s1_nxt;
            ad_s2_r <= ad_s2_nxt;
            ad_s3_r <= ad_s3_nxt;
            ad_lvl_r <= ad_lvl_nxt;
        end
    end

    // ==================================================
    // host-bus decode

    always_comb begin
        a2_nxt = 1'b0;
        a9_nxt = 1'b0;
        a10_nxt = 1'b0;
        rw_nxt = 1'b0;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        ds_nxt = 1'b0;
        cs_nxt = 1'b0;
        as_nxt = 1'b0;
        la_nxt = la_r;
        din_nxt = din_r;
        if (host_en) begin
            if (i_muxed_bus) begin
                // pin 0 as upper address bit 9
                a9_nxt = lvl[host_pin_pkg::PIN_ADDR];
                // pin 3 as upper address bit 10
                a10_nxt = lvl[host_pin_pkg::PIN_CS];
                as_nxt = as_act;
                // latch low address while strobe active, data otherwise
                // byte and strobe pipes have equal depth, so an edge and its byte land together
                if (as_act) begin
                    la_nxt = ad_lvl_r;
                end else begin
                    din_nxt = ad_lvl_r;
                end
            end else begin
                // pin 0 as address bit 2
                a2_nxt = lvl[host_pin_pkg::PIN_ADDR];
                cs_nxt = cs_act;
                din_nxt = ad_lvl_r;
            end
            if (i_double_strobe) begin
                rd_nxt = rd_act;
                wr_nxt = wr_act;
            end else begin
                rw_nxt = lvl[host_pin_pkg::PIN_RW];
                ds_nxt = ds_act;
            end
        end
    end

    // ==================================================
    // registers
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            a2_r <= 1'b0;
            a9_r <= 1'b0;
            a10_r <= 1'b0;
            rw_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            ds_r <= 1'b0;
            cs_r <= 1'b0;
            as_r <= 1'b0;
            la_r <= '0;
            din_r <= '0;
        end else if (i_ce) begin
            a2_r <= a2_nxt;
            a9_r <= a9_nxt;
            a10_r <= a10_nxt;
            rw_r <= rw_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            ds_r <= ds_nxt;
            cs_r <= cs_nxt;
            as_r <= as_nxt;
            la_r <= la_nxt;
            din_r <= din_nxt;
        end
    end

    assign o_host_addr_bit_two = a2_r;
    assign o_host_upper_addr_bit_nine = a9_r;
    assign o_host_upper_addr_bit_ten = a10_r;
    assign o_host_read_write_dir = rw_r;
    assign o_host_read_strobe = rd_r;
    assign o_host_write_strobe = wr_r;
    assign o_host_data_strobe = ds_r;
    assign o_host_chip_select = cs_r;
    assign o_host_addr_strobe = as_r;
    assign o_host_low_addr = la_r;
    assign o_host_data_in = din_r;
endmodule : host_port_pin_function_mux

//--- src/pin_sync.sv
// three-stage synchroniser with second/third agreement filter
`timescale 1ns/1ps
module pin_sync (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // pin in, filtered level out
    input wire logic i_pin,
    output logic o_level
);
    logic [2:0] stg_r;
    logic [2:0] stg_nxt;
    logic lvl_r;
    logic lvl_nxt;

    // ==================================================
    // next state
    always_comb begin
        stg_nxt = {stg_r[1:0], i_pin};
        lvl_nxt = lvl_r;
        // only stages two and three are compared, first stage is never looked at
        if (stg_r[1] == stg_r[2]) begin
            lvl_nxt = stg_r[2];
        end
    end

    // ==================================================
    // registers
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stg_r <= 3'h0;
            lvl_r <= 1'b0;
        end else if (i_ce) begin
            stg_r <= stg_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign o_level = lvl_r;
endmodule : pin_sync
